//--- logic/ftsram_pkg.sv
// shared constants and carriers for the flow-through burst memory
// assumes one clock domain; no software-visible registers
package ftsram_pkg;

  localparam int unsigned ADDR_W     = 19;
  localparam int unsigned LANES      = 4;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned LANE_W     = BYTE_W + 1;
  localparam int unsigned WORD_W     = LANES * LANE_W;
  localparam int unsigned BURST_W    = 2;
  localparam int unsigned DATA_W     = LANES * BYTE_W;

  // reset values
  localparam logic        MODE_RST   = 1'b1;
  localparam logic        DRIVE_RST  = 1'b1;
  localparam logic [BURST_W-1:0] CNT_RST   = 2'h0;
  localparam logic [BURST_W-1:0] CNT_STEP  = 2'h1;
  localparam logic [LANES-1:0]   BW_N_RST  = 4'hf;

  // data phase kind, gray coded along idle -> read -> write
  typedef enum logic [1:0] {
    FTSRAM_IDLE  = 2'h0,
    FTSRAM_READ  = 2'h1,
    FTSRAM_WRITE = 2'h3
  } ftsram_op_t;

  // one qualified edge worth of sampled controls
  typedef struct packed {
    logic             sel;
    logic             wr;
    logic             load;
    logic [LANES-1:0] bw_n;
  } ftsram_cmd_t;

endpackage

//--- logic/ftsram_burst.sv
// two-bit burst address sequencer
// assumes en_i is the qualified clock; load_i restarts the sequence
module ftsram_burst
  import ftsram_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               en_i,
  input  wire logic               load_i,
  input  wire logic               interleave_i,
  input  wire logic [BURST_W-1:0] base_i,
  output logic      [BURST_W-1:0] lsb_o
);

  logic [BURST_W-1:0] base_reg;
  logic [BURST_W-1:0] cnt_reg;
  logic [BURST_W-1:0] base_next;
  logic [BURST_W-1:0] cnt_next;

  assign base_next = load_i ? base_i : base_reg;
  assign cnt_next  = load_i ? CNT_RST : cnt_reg + CNT_STEP;
  // wraps inside a group of four
  assign lsb_o     = interleave_i ? (base_next ^ cnt_next)
                                  : (base_next + cnt_next);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_reg <= CNT_RST;
      cnt_reg  <= CNT_RST;
    end else if (en_i) begin
      base_reg <= base_next;
      cnt_reg  <= cnt_next;
    end
  end

endmodule

//--- logic/ftsram_core.sv
// synchronous bus side of a flow-through burst memory, 36-bit words
// assumes host drives all inputs synchronous to clk_i; no reset pin on
// the bus, rst_n_i is the chip power-on reset

// Operation
// - array of 524288 words, 36 bits each
// - capture all synchronous inputs on rising edge
// - clock enable high freezes all state except the burst order strap
// - clock gated by enable strobes every input except the strap and output enable
// - reads and writes back to back, no gaps
// - write enable plus byte selects, self-timed
// - byte select works only during writes
// - write enable low starts write, qualified
// - drivers off during write data phase
// - chip enables sampled, output enable asynchronous
// - low two address bits load burst counter
// - advance high steps burst address
// - advance low loads new address
// - linear or interleaved order by strap
// - strap high interleaved, low linear, static
// - selected when first, third low, second high
// - drivers off on write, emerging, deselect
// - read data from previous edge address
module ftsram_core
  import ftsram_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_qualify_n_i,
  input  wire logic [AW-1:0]     addr_i,
  input  wire logic              select1_n_i,
  input  wire logic              select2_i,
  input  wire logic              select3_n_i,
  input  wire logic              we_n_i,
  input  wire logic [LANES-1:0]  lane_wr_sel_n_i,
  input  wire logic              step_or_load_i,
  input  wire logic              out_en_n_i,
  input  wire logic              burst_mode_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic [LANES-1:0]  parity_i,
  output logic      [DATA_W-1:0] data_o,
  output logic      [LANES-1:0]  parity_o,
  output logic                   data_oe_n_o
);

  localparam int unsigned DEPTH = 1 << AW;

  ftsram_cmd_t        cmd;
  ftsram_op_t         op_reg;
  ftsram_op_t         op_next;
  logic               en;
  logic               mode_reg;
  logic               strap_taken_reg;
  logic [AW-1:0]      cur_addr_reg;
  logic [AW-1:0]      addr_next;
  logic [BURST_W-1:0] burst_lsb;
  logic               pend_wr_reg;
  logic [AW-1:0]      pend_addr_reg;
  logic [LANES-1:0]   pend_bw_n_reg;
  logic [LANES-1:0]   wr_lane;
  logic [WORD_W-1:0]  rd_word;
  logic [DATA_W-1:0]  data_reg;
  logic [LANES-1:0]   parity_reg;
  logic               drive_n_reg;
  logic               rd_hit;

  // the gated clock: every flop below except the burst order strap advances only on en
  assign en = !clk_qualify_n_i;

  assign cmd.sel  = !select1_n_i && select2_i && !select3_n_i;
  assign cmd.wr   = !we_n_i;
  assign cmd.load = !step_or_load_i;
  assign cmd.bw_n = lane_wr_sel_n_i;

  // load decides the kind of access; advance keeps the current one
  assign op_next = !cmd.load ? op_reg :
                   !cmd.sel  ? FTSRAM_IDLE :
                   cmd.wr    ? FTSRAM_WRITE : FTSRAM_READ;

  ftsram_burst u_burst (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .en_i         (en),
    .load_i       (cmd.load),
    .interleave_i (mode_reg),
    .base_i       (addr_i[BURST_W-1:0]),
    .lsb_o        (burst_lsb)
  );

  assign addr_next = cmd.load ? {addr_i[AW-1:BURST_W], burst_lsb}
                              : {cur_addr_reg[AW-1:BURST_W], burst_lsb};

  // burst order strap caught once after reset release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg        <= MODE_RST;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      mode_reg        <= burst_mode_i;
      strap_taken_reg <= 1'b1;
    end
  end

  // address/control capture; write data follows one edge later
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_reg        <= FTSRAM_IDLE;
      cur_addr_reg  <= '0;
      pend_wr_reg   <= 1'b0;
      pend_addr_reg <= '0;
      pend_bw_n_reg <= BW_N_RST;
    end else if (en) begin
      op_reg        <= op_next;
      cur_addr_reg  <= addr_next;
      pend_wr_reg   <= (op_next == FTSRAM_WRITE);
      pend_addr_reg <= addr_next;
      pend_bw_n_reg <= cmd.bw_n;
    end
  end

  assign rd_hit = pend_wr_reg && (pend_addr_reg == addr_next);

  // one storage array per byte lane, data byte plus its parity bit
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [LANE_W-1:0] mem [DEPTH];
    logic [LANE_W-1:0] wr_val;
    logic [LANE_W-1:0] rd_val;

    assign wr_lane[i] = en && pend_wr_reg && !pend_bw_n_reg[i];
    assign wr_val     = {parity_i[i], data_i[i*BYTE_W +: BYTE_W]};
    // a write landing on this edge is forwarded to a read of it
    assign rd_val     = (rd_hit && !pend_bw_n_reg[i]) ? wr_val
                                                      : mem[addr_next];
    assign rd_word[i*LANE_W +: LANE_W] = rd_val;

    always_ff @(posedge clk_i) begin
      if (wr_lane[i]) begin
        mem[pend_addr_reg] <= wr_val;
      end
    end
  end

  // output word and driver state for the coming data phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_reg    <= '0;
      parity_reg  <= '0;
      drive_n_reg <= DRIVE_RST;
    end else if (en) begin
      if (op_next == FTSRAM_READ) begin
        for (int j = 0; j < LANES; j++) begin
          data_reg[j*BYTE_W +: BYTE_W] <= rd_word[j*LANE_W +: BYTE_W];
          parity_reg[j] <= rd_word[j*LANE_W + BYTE_W];
        end
      end
      drive_n_reg <= (op_next != FTSRAM_READ);
    end
  end

  assign data_o      = data_reg;
  assign parity_o    = parity_reg;
  // output enable gates the pins without the clock
  assign data_oe_n_o = drive_n_reg || out_en_n_i;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_freeze;
    clk_qualify_n_i |=> $stable(op_reg) && $stable(cur_addr_reg)
                        && $stable(data_o) && $stable(drive_n_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable was high");

  property p_select;
    en && cmd.load && !cmd.sel |=> op_reg == FTSRAM_IDLE && drive_n_reg;
  endproperty
  a_select: assert property (p_select)
    else $error("deselect load did not idle the device");

  property p_wr_start;
    en && cmd.load && cmd.sel && !we_n_i |=> op_reg == FTSRAM_WRITE;
  endproperty
  a_wr_start: assert property (p_wr_start)
    else $error("write enable low did not start a write");

  property p_load;
    en && cmd.load && cmd.sel && we_n_i
      |=> op_reg == FTSRAM_READ && cur_addr_reg == $past(addr_i);
  endproperty
  a_load: assert property (p_load)
    else $error("load did not capture the presented address");

  property p_write_hiz;
    op_reg == FTSRAM_WRITE |-> data_oe_n_o;
  endproperty
  a_write_hiz: assert property (p_write_hiz)
    else $error("drivers on during a write data phase");

  property p_idle_hiz;
    op_reg == FTSRAM_IDLE |-> data_oe_n_o;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz)
    else $error("drivers on while deselected");

  property p_oe_async;
    out_en_n_i |-> data_oe_n_o;
  endproperty
  a_oe_async: assert property (p_oe_async)
    else $error("output enable high did not disable drivers");

  property p_step_group;
    en && !cmd.load && op_reg != FTSRAM_IDLE
      |=> cur_addr_reg[AW-1:BURST_W] == $past(cur_addr_reg[AW-1:BURST_W]);
  endproperty
  a_step_group: assert property (p_step_group)
    else $error("burst step left the four-word group");

  property p_linear;
    en && !cmd.load && !mode_reg && op_reg != FTSRAM_IDLE
      |=> cur_addr_reg[BURST_W-1:0]
          == BURST_W'($past(cur_addr_reg[BURST_W-1:0]) + CNT_STEP);
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear burst did not step by one");

  property p_burst_cycle;
    en && cmd.load ##1 (en && !cmd.load) [*4]
      |=> cur_addr_reg == $past(cur_addr_reg, 4);
  endproperty
  a_burst_cycle: assert property (p_burst_cycle)
    else $error("burst did not return to start after four steps");

  property p_lane_gate;
    wr_lane != '0 |-> pend_wr_reg && ((wr_lane & pend_bw_n_reg) == '0);
  endproperty
  a_lane_gate: assert property (p_lane_gate)
    else $error("lane written without write or with select high");

  property p_back_to_back;
    en && op_next == FTSRAM_WRITE ##1 en && op_next == FTSRAM_READ
      |=> !drive_n_reg ##0 $past(pend_wr_reg) && pend_wr_reg == 1'b0;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("write then read was not back to back");

  property p_strap_static;
    strap_taken_reg |=> $stable(mode_reg);
  endproperty
  a_strap_static: assert property (p_strap_static)
    else $error("burst order changed after it was taken");

  property p_capture;
    en && cmd.load && cmd.sel && !we_n_i
      |=> pend_wr_reg && pend_bw_n_reg == $past(lane_wr_sel_n_i);
  endproperty
  a_capture: assert property (p_capture)
    else $error("write controls not captured on the load edge");

  property p_frozen_write;
    clk_qualify_n_i |-> wr_lane == '0;
  endproperty
  a_frozen_write: assert property (p_frozen_write)
    else $error("array written on an ignored edge");

  property p_load_lsb;
    en && cmd.load
      |=> cur_addr_reg[BURST_W-1:0] == $past(addr_i[BURST_W-1:0]);
  endproperty
  a_load_lsb: assert property (p_load_lsb)
    else $error("burst counter did not start at the low address bits");

  property p_hold_kind;
    en && !cmd.load |=> op_reg == $past(op_reg);
  endproperty
  a_hold_kind: assert property (p_hold_kind)
    else $error("advance changed the access kind");

  property p_interleave;
    en && !cmd.load && mode_reg && op_reg != FTSRAM_IDLE
      |=> cur_addr_reg[0] != $past(cur_addr_reg[0]);
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved step kept the lowest address bit");

  property p_read_drive;
    en && cmd.load && cmd.sel && we_n_i |=> !drive_n_reg;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data phase did not enable the drivers");

  property p_desel_oe;
    en && cmd.load && !cmd.sel |=> data_oe_n_o;
  endproperty
  a_desel_oe: assert property (p_desel_oe)
    else $error("drivers enabled after a deselect");

  c_read:  cover property (en && op_next == FTSRAM_READ ##1 !data_oe_n_o);
  c_write: cover property (en && op_next == FTSRAM_WRITE ##1 wr_lane != '0);
  c_fwd:   cover property (en && rd_hit && op_next == FTSRAM_READ);
  c_stall: cover property (op_reg == FTSRAM_READ && clk_qualify_n_i [*2]);
  c_burst: cover property (en && !cmd.load && op_reg != FTSRAM_IDLE [*3]);

endmodule

//--- bench/ftsram_host.sv
// host controller model driving the synchronous memory bus
// assumes drive is called just after a falling edge of the bench clock
module ftsram_host
  import ftsram_pkg::*;
#(
  parameter int unsigned AW = 6
)
(
  output logic              clk_qualify_n_o,
  output logic [AW-1:0]     addr_o,
  output logic [2:0]        sel_o,
  output logic              we_n_o,
  output logic [LANES-1:0]  lane_wr_sel_n_o,
  output logic              step_or_load_o,
  output logic              out_en_n_o,
  output logic [DATA_W-1:0] data_o,
  output logic [LANES-1:0]  parity_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic desel_reg = 1'b1;

  task automatic drive(input logic cen_n, step, we_n,
    input logic [2:0] sel, input logic [AW-1:0] a,
    input logic [LANES-1:0] bw_n, input logic [DATA_W-1:0] d,
    input logic [LANES-1:0] p, input logic oe_n);
    logic ld;
    ld = !step || desel_reg;
    clk_qualify_n_o = cen_n;
    step_or_load_o = !ld;
    sel_o = sel;
    we_n_o = we_n;
    addr_o = a;
    // byte selects held through a burst
    if (ld) lane_wr_sel_n_o = bw_n;
    // data lines change every cycle, write phases included
    data_o = d;
    parity_o = p;
    out_en_n_o = oe_n;
    if (!cen_n && ld) desel_reg = (sel != 3'b010);
  endtask

  initial drive(1'b0, 1'b0, 1'b1, 3'b110, '0, 4'hf, '0, '0, 1'b0);
endmodule

//--- bench/testbench.sv
// random back-to-back traffic against an integer memory model
// assumes the host model drives the bus; both burst orders are run
module testbench
  import ftsram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AWS = 6;
  logic              clk, rst_n, mode, cen_n, we_n, step, oe_n, doe_n;
  logic [2:0]        sel;
  logic [AWS-1:0]    addr;
  logic [3:0]        bw_n, pin, pout;
  logic [31:0]       din, dout;
  logic [35:0]       mem [64];
  logic [35:0]       exp_w;
  logic [3:0]        wbw;
  logic              wpend, drv;
  int                kind, off, base, waddr, err_count, n_tests, seed;

  ftsram_host #(.AW(AWS)) u_host (.clk_qualify_n_o(cen_n), .addr_o(addr),
    .sel_o(sel), .we_n_o(we_n), .lane_wr_sel_n_o(bw_n),
    .step_or_load_o(step), .out_en_n_o(oe_n), .data_o(din), .parity_o(pin));

  ftsram_core #(.AW(AWS)) u_dut (.clk_i(clk), .rst_n_i(rst_n),
    .clk_qualify_n_i(cen_n), .addr_i(addr), .select1_n_i(sel[2]),
    .select2_i(sel[1]), .select3_n_i(sel[0]), .we_n_i(we_n),
    .lane_wr_sel_n_i(bw_n), .step_or_load_i(step), .out_en_n_i(oe_n),
    .burst_mode_i(mode), .data_i(din), .parity_i(pin), .data_o(dout),
    .parity_o(pout), .data_oe_n_o(doe_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk or negedge rst_n) begin : model_step
    int a;
    if (!rst_n) begin
      kind = 0;
      drv = 1'b0;
      wpend = 1'b0;
    end else if (!cen_n) begin
      if (wpend) for (int i = 0; i < 4; i++) if (!wbw[i]) begin
        mem[waddr][8*i+:8] = din[8*i+:8];
        mem[waddr][32+i] = pin[i];
      end
      wpend = 1'b0;
      if (!step) begin
        kind = (sel != 3'b010) ? 0 : (we_n ? 1 : 2);
        base = int'(addr);
        off = 0;
      end else if (kind != 0) off = (off + 1) % 4;
      a = (base & ~3) | (mode ? (base ^ off) & 3 : (base + off) & 3);
      if (kind == 2) begin
        wpend = 1'b1;
        waddr = a;
        wbw = bw_n;
      end
      drv = (kind == 1);
      if (drv) exp_w = mem[a];
    end
  end

  task automatic chk1(input logic g, e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t drive %b exp %b", $time, g, e);
    end
  endtask

  task automatic chkw(input logic [35:0] g, e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t word %h exp %h", $time, g, e);
    end
  endtask

  task automatic check();
    chk1(doe_n, !drv | oe_n);
    if (drv && !oe_n) chkw({pout, dout}, exp_w);
  endtask

  task automatic run(input logic m);
    int r;
    @(negedge clk);
    check();
    rst_n = 1'b0;
    mode = m;
    repeat (10) begin
      @(negedge clk);
      check();
      u_host.drive(1'b0, 1'b0, 1'b1, 3'b110, '0, 4'hf, '0, '0, 1'b0);
    end
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      check();
      u_host.drive(1'b0, 1'b0, 1'b0, 3'b010, i[AWS-1:0], 4'h0,
        $random(seed), i[3:0], 1'b0);
    end
    repeat (900) begin
      @(negedge clk);
      check();
      r = $random(seed);
      u_host.drive(r[2:0] == 0, r[2:0] > 4, r[3],
        r[2:0] == 1 ? (r[6:4] == 3'b010 ? 3'b000 : r[6:4]) : 3'b010,
        r[12:7], r[16:13], $random(seed), r[23:20],
        r[19:17] == 0);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    seed = 17220;
    err_count = 0;
    n_tests = 0;
    rst_n = 1'b0;
    mode = 1'b1;
    @(posedge clk);
    run(1'b1);
    run(1'b0);
    close_out();
  end
endmodule
